// ===== core/fmacr_regs.sv
// Alert mask, low-bit, pin/tach configuration and overtemperature timer registers.
// Assumes a serial bus engine gives one-cycle read/write strobes with address and data,
// and that the measurement engine supplies 10-bit readings and status events.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - First mask bits 1,2,4,5,6 block alert for their channel's limit events.
// - With second mask bits 7:2 all ones, gate bit 7 decides alert for second-status events.
// - Second mask bits 2,3,4 block fan one to three fault alerts.
// - Second mask bit 5 blocks fan four fault, or timer event in overtemp mode.
// - Second mask bits 6,7 block diode fault alerts for remote one and two.
// - Voltage low-bits register: core at 3:2, supply at 5:4, read-only.
// - Temperature low-bits register: remote one 3:2, local 5:4, remote two 7:6.
// - Reading low bits freezes them and upper bits until upper bits read.
// - Config bit 0 turns shared second fan pin into active-low alert output.
// - Config bit 1 with pin function field enables overtemperature pin.
// - Overtemp asserted with boost bit 2 forces fans to full duty.
// - Config bit 3 raises tach rate from once per second to every 250 ms.
// - Config bits 4 to 7 select continuous tach, no pulse stretching, per channel.
// - Lock bit makes configuration register three ignore writes.
// - Duration bits 7:1 read zero until assertion exceeds 45.52 ms.
// - Duration bit 0 sets on overtemp assertion, clears on read.
// - Beyond 45.52 ms bits 7:1 carry bits 7:1 of the count of 22.76 ms steps; bit 0 reads one.
// - Duration beyond limit register raises timer event; zero limit flags at once.
module fmacr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Lock bit and shared pin function field from other configuration registers
  input wire logic configLock,
  input wire logic [1:0] sharedPinFunction,
  // Live 10-bit readings and reads of their upper-bit registers
  input wire logic [9:0] coreVoltage,
  input wire logic [9:0] supplyVoltage,
  input wire logic [9:0] remoteOneTemp,
  input wire logic [9:0] localTemp,
  input wire logic [9:0] remoteTwoTemp,
  input wire logic [4:0] upperBitsRead,
  output logic [39:0] heldUpperBits,
  // Status events from the measurement engine
  input wire logic [7:0] firstStatus,
  input wire logic [7:0] secondStatus,
  input wire logic overtempSignal,
  // Pin and fan controls
  output logic alertActiveN,
  output logic sharedPinIsAlert,
  output logic overtempPinEnable,
  output logic fanFullSpeed,
  output logic [3:0] continuousSense,
  output logic tachTick,
  output logic timerEvent
);
  logic [7:0] maskFirst_q;
  logic [7:0] maskSecond_q;
  logic [7:0] pinTachCfg_q;
  logic [7:0] timeLimit_q;
  logic [7:0] durCount_q;
  logic seenFlag_q;
  logic [31:0] stepCnt_q;
  logic [31:0] tachCnt_q;
  logic overtempLast_q;
  logic timerEvent_q;
  logic [7:0] regRdata_q;
  logic [9:0] held [5];

  // Address decode
  wire logic hitFirst = (regAddr == fmacr_pkg::ADDR_MASK_FIRST);
  wire logic hitSecond = (regAddr == fmacr_pkg::ADDR_MASK_SECOND);
  wire logic hitVolt = (regAddr == fmacr_pkg::ADDR_VOLT_LOW);
  wire logic hitTemp = (regAddr == fmacr_pkg::ADDR_TEMP_LOW);
  wire logic hitCfg = (regAddr == fmacr_pkg::ADDR_PIN_TACH_CFG);
  wire logic hitDur = (regAddr == fmacr_pkg::ADDR_DURATION);
  wire logic hitLimit = (regAddr == fmacr_pkg::ADDR_TIME_LIMIT);
  wire logic cfgWrite = regWrite && hitCfg && !configLock;
  wire logic durRead = regRead && hitDur;

  // Overtemperature input qualified by pin enable and function field
  wire logic overtempMode = pinTachCfg_q[fmacr_pkg::CF_OVERTEMP]
    && (sharedPinFunction == fmacr_pkg::PIN_FUNC_OVERTEMP);
  wire logic overtempActive = overtempMode && overtempSignal;
  wire logic overtempRise = overtempActive && !overtempLast_q;

  // Freeze holders for the five readings
  logic [9:0] liveData [5];
  logic [4:0] freezeReqs;
  assign liveData[0] = coreVoltage;
  assign liveData[1] = supplyVoltage;
  assign liveData[2] = remoteOneTemp;
  assign liveData[3] = localTemp;
  assign liveData[4] = remoteTwoTemp;
  assign freezeReqs = {{3{regRead && hitTemp}}, {2{regRead && hitVolt}}};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : gHold
      fmacr_freeze_if frz ();
      assign frz.live = liveData[gi];
      assign frz.freezeReq = freezeReqs[gi];
      assign frz.upperRead = upperBitsRead[gi];
      assign held[gi] = frz.held;
      assign heldUpperBits[gi*8 +: 8] = frz.held[9:2];
      fmacr_hold uHold (
        .clk(clk),
        .rst(rst),
        .fr(frz)
      );
    end
  endgenerate

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskFirst_q <= fmacr_pkg::RESET_BYTE;
      maskSecond_q <= fmacr_pkg::RESET_BYTE;
      pinTachCfg_q <= fmacr_pkg::RESET_BYTE;
      timeLimit_q <= fmacr_pkg::RESET_BYTE;
    end else begin
      if (regWrite && hitFirst) begin
        maskFirst_q <= regWdata;
      end
      if (regWrite && hitSecond) begin
        // Bit 1 is read-only and reads zero
        maskSecond_q <= {regWdata[7:2], 2'b00};
      end
      if (cfgWrite) begin
        pinTachCfg_q <= regWdata;
      end
      if (regWrite && hitLimit) begin
        timeLimit_q <= regWdata;
      end
    end
  end

  // Overtemperature duration timer
  wire logic stepDone = (stepCnt_q == 32'(fmacr_pkg::STEP_CYCLES - 1));
  wire logic countSat = (durCount_q == 8'hFF);
  wire logic durOver = durCount_q >= 8'h02;
  wire logic limitHit = overtempActive && ((timeLimit_q == 8'h00)
    || (durCount_q > timeLimit_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepCnt_q <= 32'h0000_0000;
      durCount_q <= 8'h00;
      overtempLast_q <= 1'b0;
    end else begin
      overtempLast_q <= overtempActive;
      if (overtempRise) begin
        stepCnt_q <= 32'h0000_0000;
        durCount_q <= 8'h00;
      end else if (overtempActive) begin
        stepCnt_q <= stepDone ? 32'h0000_0000 : stepCnt_q + 32'h0000_0001;
        if (stepDone && !countSat) begin
          durCount_q <= durCount_q + 8'h01;
        end
      end
    end
  end

  // Assertion seen flag: set wins over the read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seenFlag_q <= 1'b0;
    end else if (overtempRise) begin
      seenFlag_q <= 1'b1;
    end else if (durRead) begin
      seenFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerEvent_q <= 1'b0;
    end else begin
      timerEvent_q <= limitHit;
    end
  end

  // Beyond two steps bits 7:1 carry the count's bits 7:1 and drop its low bit; bit 0 stays high
  wire logic [7:0] durationRead = durOver
    ? {durCount_q[7:1], 1'b1} : {7'h00, seenFlag_q};

  // Read data
  wire logic [7:0] voltLow = {2'b00, held[1][1:0], held[0][1:0], 2'b00};
  wire logic [7:0] tempLow = {held[4][1:0], held[3][1:0], held[2][1:0], 2'b00};
  logic [7:0] readMux;
  always_comb begin
    readMux = 8'h00;
    if (hitFirst) begin
      readMux = maskFirst_q;
    end else if (hitSecond) begin
      readMux = maskSecond_q;
    end else if (hitVolt) begin
      readMux = voltLow;
    end else if (hitTemp) begin
      readMux = tempLow;
    end else if (hitCfg) begin
      readMux = pinTachCfg_q;
    end else if (hitDur) begin
      readMux = durationRead;
    end else if (hitLimit) begin
      readMux = timeLimit_q;
    end
  end

  // Held low bits are sampled at the read so the freeze and the answer agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata_q <= 8'h00;
    end else if (regRead) begin
      regRdata_q <= readMux;
    end
  end
  assign regRdata = regRdata_q;

  // Alert combine
  wire logic [7:0] firstMaskUsed = maskFirst_q & 8'h76;
  wire logic firstPending = |(firstStatus & ~firstMaskUsed & 8'h76);
  // Second status bit 5 is fan four fault or, in overtemp mode, the timer event
  wire logic [7:0] secondEvents = overtempMode
    ? {secondStatus[7:6], timerEvent_q, secondStatus[4:0]}
    : secondStatus;
  wire logic [7:0] secondMaskUsed = {maskSecond_q[7:2], 2'b00};
  wire logic secondPending = |(secondEvents & ~secondMaskUsed & 8'hFE);
  wire logic secondAllMasked = (maskSecond_q[7:2] == 6'h3F);
  wire logic secondRaw = |(secondEvents & 8'hFE);
  // When every mask is set the gate bit alone decides
  wire logic secondAlert = secondAllMasked
    ? (secondRaw && !maskFirst_q[fmacr_pkg::MF_GATE]) : secondPending;
  assign alertActiveN = !(firstPending || secondAlert);

  // Pin and fan controls
  assign sharedPinIsAlert = pinTachCfg_q[fmacr_pkg::CF_ALERT];
  assign overtempPinEnable = overtempMode;
  assign fanFullSpeed = overtempActive && pinTachCfg_q[fmacr_pkg::CF_BOOST];
  assign continuousSense = pinTachCfg_q[7:fmacr_pkg::CF_CONT_LO];
  assign timerEvent = timerEvent_q;

  // Tach measurement period
  wire logic [31:0] tachPeriod = pinTachCfg_q[fmacr_pkg::CF_FAST]
    ? 32'(fmacr_pkg::FAST_CYCLES - 1) : 32'(fmacr_pkg::SLOW_CYCLES - 1);
  wire logic tachDone = (tachCnt_q >= tachPeriod);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tachCnt_q <= 32'h0000_0000;
    end else begin
      tachCnt_q <= tachDone ? 32'h0000_0000 : tachCnt_q + 32'h0000_0001;
    end
  end
  assign tachTick = tachDone;
endmodule
`default_nettype wire

// ===== pkg/fmacr_pkg.sv
// Package for the fan monitor alert and configuration register bank.
// Assumes an internal register port (address, write/read strobes) from a serial bus engine.
package fmacr_pkg;
  localparam logic [7:0] ADDR_MASK_FIRST = 8'h74;
  localparam logic [7:0] ADDR_MASK_SECOND = 8'h75;
  localparam logic [7:0] ADDR_VOLT_LOW = 8'h76;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h77;
  localparam logic [7:0] ADDR_PIN_TACH_CFG = 8'h78;
  localparam logic [7:0] ADDR_DURATION = 8'h79;
  localparam logic [7:0] ADDR_TIME_LIMIT = 8'h7A;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // First mask fields
  localparam int MF_CORE = 1;
  localparam int MF_SUPPLY = 2;
  localparam int MF_REMOTE_ONE = 4;
  localparam int MF_LOCAL = 5;
  localparam int MF_REMOTE_TWO = 6;
  localparam int MF_GATE = 7;
  // Second mask fields
  localparam int MS_OVERTEMP = 1;
  localparam int MS_FAN_ONE = 2;
  localparam int MS_FAN_FOUR = 5;
  localparam int MS_DIODE_ONE = 6;
  localparam int MS_DIODE_TWO = 7;
  // Pin and tach configuration fields
  localparam int CF_ALERT = 0;
  localparam int CF_OVERTEMP = 1;
  localparam int CF_BOOST = 2;
  localparam int CF_FAST = 3;
  localparam int CF_CONT_LO = 4;
  // Shared pin function code that selects the overtemperature role
  localparam logic [1:0] PIN_FUNC_OVERTEMP = 2'h1;
  // Timing
  localparam real CLK_MHZ = 40.0;
  localparam real STEP_MS = 22.76;
  localparam int STEP_CYCLES = int'($floor(STEP_MS * CLK_MHZ * 1000.0));
  localparam real FAST_MS = 250.0;
  localparam real SLOW_MS = 1000.0;
  localparam int FAST_CYCLES = int'($floor(FAST_MS * CLK_MHZ * 1000.0));
  localparam int SLOW_CYCLES = int'($floor(SLOW_MS * CLK_MHZ * 1000.0));
endpackage

// ===== pkg/fmacr_freeze_if.sv
// Interface between the bank and its low-bit freeze holders.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface fmacr_freeze_if;
  logic [9:0] live;
  logic freezeReq;
  logic upperRead;
  logic [9:0] held;
  modport bank (output live, output freezeReq, output upperRead, input held);
  modport holder (input live, input freezeReq, input upperRead, output held);
endinterface
`default_nettype wire

// ===== core/fmacr_hold.sv
// One frozen 10-bit reading: tracks live data until frozen, released when upper bits read.
// Assumes the bank decodes the freezing and releasing reads.
`timescale 1ns/1ps
`default_nettype none
module fmacr_hold (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bank side
  fmacr_freeze_if.holder fr
);
  logic frozen_q;
  logic [9:0] held_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen_q <= 1'b0;
    end else if (fr.freezeReq) begin
      frozen_q <= 1'b1;
    end else if (fr.upperRead) begin
      frozen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_q <= 10'h000;
    end else if (!frozen_q && !fr.freezeReq) begin
      held_q <= fr.live;
    end
  end

  assign fr.held = held_q;
endmodule
`default_nettype wire

// ===== verif/fmacr_regs_assertions.sv
// Port checks for the alert mask and configuration register bank.
// Assumes one clock domain, rst asynchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module fmacr_regs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic configLock,
  // Events and pins
  input wire logic [7:0] firstStatus,
  input wire logic [7:0] secondStatus,
  input wire logic overtempSignal,
  input wire logic timerEvent,
  input wire logic alertActiveN,
  input wire logic sharedPinIsAlert,
  input wire logic overtempPinEnable,
  input wire logic fanFullSpeed,
  input wire logic [3:0] continuousSense,
  input wire logic tachTick
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cfgWr;
  logic [5:0] cfgPins;
  assign cfgWr = regWrite && regAddr == fmacr_pkg::ADDR_PIN_TACH_CFG;
  assign cfgPins = {continuousSense, overtempPinEnable, sharedPinIsAlert};
  property p_cfgBits;
    cfgWr && !configLock |=> cfgPins == {$past(regWdata[7:4]), $past(regWdata[1:0])};
  endproperty
  a_cfgBits: assert property (p_cfgBits) else $error("config pins");
  property p_lock; cfgWr && configLock |=> $stable(cfgPins); endproperty
  a_lock: assert property (p_lock) else $error("locked write");
  property p_idle; firstStatus == 8'h00 && secondStatus == 8'h00 && !timerEvent |-> alertActiveN; endproperty
  a_idle: assert property (p_idle) else $error("alert idle");
  property p_volt;
    regRead && regAddr == fmacr_pkg::ADDR_VOLT_LOW |=> regRdata[1:0] == 2'h0 && regRdata[7:6] == 2'h0;
  endproperty
  a_volt: assert property (p_volt) else $error("volt low bits");
  property p_temp; regRead && regAddr == fmacr_pkg::ADDR_TEMP_LOW |=> regRdata[1:0] == 2'h0; endproperty
  a_temp: assert property (p_temp) else $error("temp low bits");
  property p_fan; !overtempSignal |-> !fanFullSpeed; endproperty
  a_fan: assert property (p_fan) else $error("full speed");
  property p_tick; tachTick |=> !tachTick; endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_timer; !overtempSignal [*2] |-> !timerEvent; endproperty
  a_timer: assert property (p_timer) else $error("timer event");
endmodule
bind fmacr_regs fmacr_regs_assertions i_fmacr_regs_assertions (
  .clk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .configLock,
  .firstStatus, .secondStatus, .overtempSignal, .timerEvent, .alertActiveN,
  .sharedPinIsAlert, .overtempPinEnable, .fanFullSpeed, .continuousSense, .tachTick
);
`default_nettype wire

// ===== verif/fmacr_host.sv
// Serial bus host model: one register transfer at a time on the bank's port.
// Assumes reads answer at the taking edge; the answer is sampled half a cycle later.
`timescale 1ns/1ps
`default_nettype none
module fmacr_host (
  // Clock and answer
  input wire logic clk,
  input wire logic [7:0] regRdata,
  // Requests
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = wr;
    regRead = !wr;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    // Idle lines flip so a stale address or datum never looks valid
    regAddr = ~a;
    regWdata = ~d;
    q = regRdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the alert mask and configuration register bank.
// Assumes the host model in front of the register port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic configLock = 1'b0;
  logic [1:0] sharedPinFunction = fmacr_pkg::PIN_FUNC_OVERTEMP;
  logic [9:0] rd [5] = '{10'h2B6, 10'h1C9, 10'h0F7, 10'h35C, 10'h1E6};
  logic [4:0] upperBitsRead = 5'h00;
  logic [7:0] firstStatus = 8'h00;
  logic [7:0] secondStatus = 8'h00;
  logic overtempSignal = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regWrite, regRead, alertActiveN, sharedPinIsAlert, overtempPinEnable;
  logic fanFullSpeed, tachTick, timerEvent;
  logic [3:0] continuousSense;
  logic [39:0] heldUpperBits;
  int fails = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  fmacr_host i_fmacr_host (.clk, .regRdata, .regAddr, .regWrite, .regRead, .regWdata);
  fmacr_regs i_fmacr_regs (
    .clk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .configLock,
    .sharedPinFunction, .coreVoltage(rd[0]), .supplyVoltage(rd[1]),
    .remoteOneTemp(rd[2]), .localTemp(rd[3]), .remoteTwoTemp(rd[4]), .upperBitsRead,
    .heldUpperBits, .firstStatus, .secondStatus, .overtempSignal, .alertActiveN,
    .sharedPinIsAlert, .overtempPinEnable, .fanFullSpeed, .continuousSense, .tachTick,
    .timerEvent
  );
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_fmacr_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_fmacr_host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  function automatic logic [7:0] lowBits(input int lo, input int hi);
    logic [7:0] v;
    v = 8'h00;
    for (int i = lo; i <= hi; i++) v[2*(i-lo)+2 +: 2] = rd[i][1:0];
    return v;
  endfunction
  task automatic test_reset();
    rdc(fmacr_pkg::ADDR_MASK_SECOND, 8'h00);
    rdc(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h00);
    rdc(fmacr_pkg::ADDR_DURATION, 8'h00);
    rdc(8'hC3, 8'h00);
  endtask
  // Each used status bit alone pulls the alert low until its own mask bit is set
  task automatic test_mask(input logic [7:0] a, input logic [7:0] used);
    for (int b = 0; b < 8; b++) begin
      if (used[b]) begin
        @(negedge clk);
        if (a == fmacr_pkg::ADDR_MASK_FIRST) firstStatus = 8'h01 << b;
        else secondStatus = 8'h01 << b;
        #1;
        chk({7'h00, alertActiveN}, 8'h00);
        wr(a, 8'h01 << b);
        chk({7'h00, alertActiveN}, 8'h01);
        wr(a, 8'h00);
        firstStatus = 8'h00;
        secondStatus = 8'h00;
      end
    end
  endtask
  task automatic test_config();
    wr(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'hF3);
    chk({2'h0, continuousSense, overtempPinEnable, sharedPinIsAlert}, 8'h3F);
    configLock = 1'b1;
    wr(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h0C);
    rdc(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'hF3);
    configLock = 1'b0;
    wr(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h00);
    rdc(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h00);
  endtask
  // With every second mask set, only the gate bit decides the alert
  task automatic test_gate();
    wr(fmacr_pkg::ADDR_MASK_SECOND, 8'hFC);
    secondStatus = 8'h04;
    #1;
    chk({7'h00, alertActiveN}, 8'h00);
    wr(fmacr_pkg::ADDR_MASK_FIRST, 8'h80);
    chk({7'h00, alertActiveN}, 8'h01);
    wr(fmacr_pkg::ADDR_MASK_FIRST, 8'h00);
    wr(fmacr_pkg::ADDR_MASK_SECOND, 8'h00);
    secondStatus = 8'h00;
  endtask
  task automatic test_freeze(input logic [7:0] a, input int lo, input int hi);
    logic [7:0] frozen;
    logic [39:0] up;
    frozen = lowBits(lo, hi);
    for (int i = lo; i <= hi; i++) up[8*i +: 8] = rd[i][9:2];
    rdc(a, frozen);
    for (int i = lo; i <= hi; i++) rd[i] = ~rd[i];
    rdc(a, frozen);
    for (int i = lo; i <= hi; i++) chk(heldUpperBits[8*i +: 8], up[8*i +: 8]);
    for (int i = lo; i <= hi; i++) upperBitsRead[i] = 1'b1;
    @(negedge clk);
    upperBitsRead = 5'h00;
    @(negedge clk);
    for (int i = lo; i <= hi; i++) chk(heldUpperBits[8*i +: 8], rd[i][9:2]);
    rdc(a, lowBits(lo, hi));
  endtask
  task automatic test_overtemp();
    wr(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h06);
    rdc(fmacr_pkg::ADDR_DURATION, 8'h00);
    overtempSignal = 1'b1;
    @(negedge clk);
    chk({7'h00, fanFullSpeed}, 8'h01);
    rdc(fmacr_pkg::ADDR_DURATION, 8'h01);
    rdc(fmacr_pkg::ADDR_DURATION, 8'h00);
    chk({7'h00, timerEvent}, 8'h01);
    chk({7'h00, alertActiveN}, 8'h00);
    wr(fmacr_pkg::ADDR_MASK_SECOND, 8'h20);
    chk({7'h00, alertActiveN}, 8'h01);
    wr(fmacr_pkg::ADDR_TIME_LIMIT, 8'h05);
    // The timer event is registered, so the new limit shows one edge later
    @(negedge clk);
    chk({7'h00, timerEvent}, 8'h00);
    wr(fmacr_pkg::ADDR_PIN_TACH_CFG, 8'h02);
    chk({7'h00, fanFullSpeed}, 8'h00);
    overtempSignal = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_mask(fmacr_pkg::ADDR_MASK_FIRST, 8'h76);
    test_mask(fmacr_pkg::ADDR_MASK_SECOND, 8'hFC);
    test_config();
    test_gate();
    test_freeze(fmacr_pkg::ADDR_VOLT_LOW, 0, 1);
    test_freeze(fmacr_pkg::ADDR_TEMP_LOW, 2, 4);
    test_overtemp();
    complete_run();
  end
  // The whole run takes about 120 cycles; this limit of 3000 cycles leaves wide margin
  initial begin
    #75000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
